// >>> host_model.sv
// host processor model driving the byte port
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input  wire logic                         ref_clk,
  input  wire logic                         host_ready,
  output var  logic                         host_valid,
  output var  lcd_pixel_pkg::host_byte_type host_byte,
  output var  logic                         chip_select_n,
  output var  logic                         read_strobe_n
);
  initial {host_valid, host_byte, chip_select_n, read_strobe_n} = 12'h003;
  // valid stays up between back-to-back bytes
  task automatic send(input logic sel, input logic [7:0] d);
    host_valid <= 1'b1;
    host_byte <= {sel, d};
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b1;
    do @(posedge ref_clk); while (!host_ready);
  endtask : send
  // released bus shows the inverse so stale data cannot pass
  task automatic idle;
    host_valid <= 1'b0;
    host_byte <= ~host_byte;
    @(posedge ref_clk);
  endtask : idle
  // ignored bytes: deselected, then read strobe low
  task automatic junk(input logic [7:0] d);
    host_valid <= 1'b1;
    host_byte <= {1'b1, d};
    chip_select_n <= 1'b1;
    @(posedge ref_clk);
    chip_select_n <= 1'b0;
    read_strobe_n <= 1'b0;
    @(posedge ref_clk);
    read_strobe_n <= 1'b1;
    host_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : junk
endmodule : host_model
`default_nettype wire

// >>> lcd_pixel_checker.sv
// assertion checker bound to the pixel write block
`timescale 1ns/1ns
`default_nettype none
module lcd_pixel_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        host_valid,
  input wire logic        host_ready,
  input wire logic        chip_select_n,
  input wire logic        read_strobe_n,
  input wire logic        pixel_valid,
  input wire logic        pixel_ready,
  input wire logic [25:0] pixel_out,
  input wire logic [6:0]  contrast_level,
  input wire logic        resistor_select_bit,
  input wire logic [1:0]  temp_gradient,
  input wire logic        bias_select_msb,
  input wire logic        bias_select_mid,
  input wire logic        bias_select_lsb
);
  logic take, ev;
  assign take = host_valid && host_ready && !chip_select_n && read_strobe_n;
  assign ev = (avs_write && !avs_waitrequest) || take;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==================
  // bus and stream
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("no single wait");
  property p_no_req; !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_no_req: assert property (p_no_req) else $error("stray wait");
  property p_hold;
    pixel_valid && !pixel_ready |=> pixel_valid && $stable(pixel_out);
  endproperty
  a_hold: assert property (p_hold) else $error("pixel lost");
  property p_full; !host_ready |-> pixel_valid; endproperty
  a_full: assert property (p_full) else $error("refused empty");
  property p_rise; $rose(pixel_valid) |-> $past(take); endproperty
  a_rise: assert property (p_rise) else $error("pixel late");
  property p_quiet; !pixel_valid && !take |=> !pixel_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("pixel unasked");
  // ==================
  // power selects
  property p_power;
    $changed({resistor_select_bit, temp_gradient, bias_select_msb,
      bias_select_mid, bias_select_lsb}) |-> $past(avs_write);
  endproperty
  a_power: assert property (p_power) else $error("select moved");
  property p_level;
    $changed(contrast_level) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3);
  endproperty
  a_level: assert property (p_level) else $error("level moved");
endmodule : lcd_pixel_checker
bind lcd_pixel_write_and_contrast lcd_pixel_checker chk_u (.ref_clk, .rst,
  .avs_read, .avs_write, .avs_waitrequest, .host_valid, .host_ready,
  .chip_select_n, .read_strobe_n, .pixel_valid, .pixel_ready, .pixel_out,
  .contrast_level, .resistor_select_bit, .temp_gradient, .bias_select_msb,
  .bias_select_mid, .bias_select_lsb);
`default_nettype wire

// >>> lcd_pixel_pkg.sv
// constants, field layouts and carrier types for the pixel write block
package lcd_pixel_pkg;

  // ==================
  // byte port commands and their parameter counts
  localparam logic [7:0] CMD_WRITE_CONTRAST = 8'h25;
  localparam logic [7:0] CMD_COLUMN_SET     = 8'h2A;
  localparam logic [7:0] CMD_PAGE_SET       = 8'h2B;
  localparam logic [7:0] CMD_MEMORY_WRITE   = 8'h2C;
  localparam logic [7:0] CMD_COLOUR_SET     = 8'h2D;
  localparam logic [4:0] PARAMS_ADDRESS     = 5'h02;
  localparam logic [4:0] PARAMS_COLOUR      = 5'h14;

  // ==================
  // colour table layout: eight red, eight green, four blue entries
  localparam int         TABLE_DEPTH        = 20;
  localparam logic [4:0] TABLE_GREEN_BASE   = 5'h08;
  localparam logic [4:0] TABLE_BLUE_BASE    = 5'h10;

  // ==================
  // contrast arithmetic
  localparam logic [8:0] CONTRAST_OFFSET    = 9'h03F;
  localparam logic [8:0] CONTRAST_MAX       = 9'h07F;
  localparam logic [6:0] VOLTAGE_RESET      = 7'h3F;
  localparam logic [6:0] CONTRAST_RESET     = 7'h00;

  // ==================
  // address window defaults
  localparam logic [6:0] COLUMN_LAST_RESET  = 7'h67;
  localparam logic [6:0] PAGE_LAST_RESET    = 7'h53;

  // ==================
  // register byte addresses
  localparam logic [4:0] REG_CTRL           = 5'h00;
  localparam logic [4:0] REG_VOLTAGE        = 5'h04;
  localparam logic [4:0] REG_CONTRAST       = 5'h08;
  localparam logic [4:0] REG_STATUS         = 5'h0C;
  localparam logic [4:0] REG_PIXEL_COUNT    = 5'h10;

  // ==================
  // buffer
  localparam logic [1:0] BUF_DEPTH          = 2'h2;

  // ==================
  // types
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_PARAM = 2'h1,
    ST_WRITE = 2'h3
  } state_type;

  // memory_access_order: [0] page steps first, [1] column reversed,
  // [2] page reversed
  typedef struct packed {
    logic [2:0] bias_select;
    logic [1:0] temp_gradient;
    logic       resistor_select_bit;
    logic [2:0] memory_access_order;
    logic       colour_mode_8bit;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '0;

  typedef struct packed {
    logic       data_command_select;
    logic [7:0] data;
  } host_byte_type;

  typedef struct packed {
    logic [6:0]  column;
    logic [6:0]  page;
    logic [11:0] pixel;
  } pixel_write_type;

endpackage : lcd_pixel_pkg

// >>> lcd_pixel_write_and_contrast.sv
// host byte port, pixel packing, colour table, contrast and power selects
`timescale 1ns/1ns
`default_nettype none

module lcd_pixel_write_and_contrast (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic [4:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output var  logic [31:0]                   avs_readdata,
  output var  logic                          avs_waitrequest,
  input  wire logic                          host_valid,
  output var  logic                          host_ready,
  input  wire lcd_pixel_pkg::host_byte_type  host_byte,
  input  wire logic                          chip_select_n,
  input  wire logic                          read_strobe_n,
  output var  logic                          pixel_valid,
  input  wire logic                          pixel_ready,
  output var  lcd_pixel_pkg::pixel_write_type pixel_out,
  output var  logic [6:0]                    contrast_level,
  output var  logic                          resistor_select_bit,
  output var  logic [1:0]                    temp_gradient,
  output var  logic                          bias_select_msb,
  output var  logic                          bias_select_mid,
  output var  logic                          bias_select_lsb
);

  // ==================
  // functions
  // one step along a window; top bit flags the wrap back to the start
  function automatic logic [7:0] step_addr(input logic [6:0] cur,
                                           input logic [6:0] first,
                                           input logic [6:0] last,
                                           input logic       rev);
    logic [7:0] r;
    r = {1'b0, cur};
    if (!rev) begin
      r = (cur == last) ? {1'b1, first} : {1'b0, 7'(cur + 7'h01)};
    end else begin
      r = (cur == first) ? {1'b1, last} : {1'b0, 7'(cur - 7'h01)};
    end
    return r;
  endfunction : step_addr

  function automatic logic [31:0] merge_lanes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_lanes

  // ==================
  // state
  lcd_pixel_pkg::state_type       state_reg, state_next;
  lcd_pixel_pkg::ctrl_type        ctrl_reg, ctrl_next;
  logic [7:0]                     cmd_reg, cmd_next;
  logic [4:0]                     count_reg, count_next;
  logic [1:0]                     phase_reg, phase_next;
  logic [7:0]                     hold_reg, hold_next;
  logic [6:0]                     col_first_reg, col_first_next;
  logic [6:0]                     col_last_reg, col_last_next;
  logic [6:0]                     page_first_reg, page_first_next;
  logic [6:0]                     page_last_reg, page_last_next;
  logic [6:0]                     col_reg, col_next;
  logic [6:0]                     page_reg, page_next;
  logic [6:0]                     voltage_reg, voltage_next;
  logic [6:0]                     contrast_reg, contrast_next;
  logic [6:0]                     level_reg, level_next;
  logic [15:0]                    pix_count_reg, pix_count_next;
  logic [3:0]                     table_reg [lcd_pixel_pkg::TABLE_DEPTH];
  logic [3:0]                     table_next [lcd_pixel_pkg::TABLE_DEPTH];
  logic                           push_valid;
  lcd_pixel_pkg::pixel_write_type push_data;
  logic                           byte_take;
  logic                           bus_wr;
  logic [8:0]                     alpha;
  logic [7:0]                     col_step, page_step;
  logic [11:0]                    lut_pixel;

  // bus side
  logic                           ack_reg, ack_next;
  logic [31:0]                    rdata_reg, rdata_next;
  logic [31:0]                    old_word, new_word;

  // buffer
  lcd_pixel_pkg::pixel_write_type buf_reg [2];
  lcd_pixel_pkg::pixel_write_type buf_next [2];
  logic [1:0]                     buf_count_reg, buf_count_next;
  logic                           pop;

  // ==================
  // host byte port
  // ready only on free space, so a stalled receiver back-pressures the host
  assign host_ready = (buf_count_reg != lcd_pixel_pkg::BUF_DEPTH);
  assign byte_take  = host_valid & host_ready & ~chip_select_n &
                      read_strobe_n;
  assign bus_wr     = avs_write & ack_reg;

  assign col_step  = step_addr(col_reg, col_first_reg, col_last_reg,
                               ctrl_reg.memory_access_order[1]);
  assign page_step = step_addr(page_reg, page_first_reg, page_last_reg,
                               ctrl_reg.memory_access_order[2]);
  assign lut_pixel = {
    table_reg[host_byte.data[7:5]],
    table_reg[lcd_pixel_pkg::TABLE_GREEN_BASE + 5'(host_byte.data[4:2])],
    table_reg[lcd_pixel_pkg::TABLE_BLUE_BASE + 5'(host_byte.data[1:0])]
  };

  always_comb begin
    state_next      = state_reg;
    ctrl_next       = ctrl_reg;
    cmd_next        = cmd_reg;
    count_next      = count_reg;
    phase_next      = phase_reg;
    hold_next       = hold_reg;
    col_first_next  = col_first_reg;
    col_last_next   = col_last_reg;
    page_first_next = page_first_reg;
    page_last_next  = page_last_reg;
    col_next        = col_reg;
    page_next       = page_reg;
    voltage_next    = voltage_reg;
    contrast_next   = contrast_reg;
    pix_count_next  = pix_count_reg;
    table_next      = table_reg;
    push_valid      = 1'b0;
    push_data       = '{column: col_reg, page: page_reg, pixel: lut_pixel};
    old_word        = '0;
    new_word        = '0;

    if (bus_wr) begin
      case (avs_address)
        lcd_pixel_pkg::REG_CTRL: begin
          old_word  = 32'(ctrl_reg);
          new_word  = merge_lanes(old_word, avs_writedata, avs_byteenable);
          ctrl_next = lcd_pixel_pkg::ctrl_type'(new_word[9:0]);
        end
        lcd_pixel_pkg::REG_VOLTAGE: begin
          old_word     = 32'(voltage_reg);
          new_word     = merge_lanes(old_word, avs_writedata, avs_byteenable);
          voltage_next = new_word[6:0];
        end
        lcd_pixel_pkg::REG_CONTRAST: begin
          old_word      = 32'(contrast_reg);
          new_word      = merge_lanes(old_word, avs_writedata, avs_byteenable);
          contrast_next = new_word[6:0];
        end
        default: begin
        end
      endcase
    end

    if (byte_take) begin
      if (!host_byte.data_command_select) begin
        // any command drops a half-received pixel, so nothing half-done is stored
        cmd_next   = host_byte.data;
        count_next = '0;
        phase_next = '0;
        case (host_byte.data)
          lcd_pixel_pkg::CMD_MEMORY_WRITE: begin
            state_next = lcd_pixel_pkg::ST_WRITE;
            col_next   = ctrl_reg.memory_access_order[1] ?
                         col_last_reg : col_first_reg;
            page_next  = ctrl_reg.memory_access_order[2] ?
                         page_last_reg : page_first_reg;
          end
          lcd_pixel_pkg::CMD_WRITE_CONTRAST,
          lcd_pixel_pkg::CMD_COLUMN_SET,
          lcd_pixel_pkg::CMD_PAGE_SET,
          lcd_pixel_pkg::CMD_COLOUR_SET: begin
            state_next = lcd_pixel_pkg::ST_PARAM;
          end
          default: begin
            state_next = lcd_pixel_pkg::ST_IDLE;
          end
        endcase
      end else begin
        case (state_reg)
          lcd_pixel_pkg::ST_PARAM: begin
            count_next = 5'(count_reg + 5'h01);
            case (cmd_reg)
              lcd_pixel_pkg::CMD_WRITE_CONTRAST: begin
                contrast_next = host_byte.data[6:0];
                state_next    = lcd_pixel_pkg::ST_IDLE;
              end
              lcd_pixel_pkg::CMD_COLUMN_SET: begin
                if (count_reg == 5'h00) begin
                  col_first_next = host_byte.data[6:0];
                end else begin
                  col_last_next = host_byte.data[6:0];
                end
                if (count_next == lcd_pixel_pkg::PARAMS_ADDRESS) begin
                  state_next = lcd_pixel_pkg::ST_IDLE;
                end
              end
              lcd_pixel_pkg::CMD_PAGE_SET: begin
                if (count_reg == 5'h00) begin
                  page_first_next = host_byte.data[6:0];
                end else begin
                  page_last_next = host_byte.data[6:0];
                end
                if (count_next == lcd_pixel_pkg::PARAMS_ADDRESS) begin
                  state_next = lcd_pixel_pkg::ST_IDLE;
                end
              end
              lcd_pixel_pkg::CMD_COLOUR_SET: begin
                table_next[count_reg] = host_byte.data[3:0];
                if (count_next == lcd_pixel_pkg::PARAMS_COLOUR) begin
                  state_next = lcd_pixel_pkg::ST_IDLE;
                end
              end
              default: begin
                state_next = lcd_pixel_pkg::ST_IDLE;
              end
            endcase
          end
          lcd_pixel_pkg::ST_WRITE: begin
            if (ctrl_reg.colour_mode_8bit) begin
              push_valid = 1'b1;
            end else begin
              case (phase_reg)
                2'h0: begin
                  hold_next  = host_byte.data;
                  phase_next = 2'h1;
                end
                2'h1: begin
                  push_valid      = 1'b1;
                  push_data.pixel = {hold_reg, host_byte.data[7:4]};
                  hold_next       = {4'h0, host_byte.data[3:0]};
                  phase_next      = 2'h2;
                end
                default: begin
                  push_valid      = 1'b1;
                  push_data.pixel = {hold_reg[3:0], host_byte.data};
                  phase_next      = 2'h0;
                end
              endcase
            end
            if (push_valid) begin
              pix_count_next = 16'(pix_count_reg + 16'h0001);
              if (ctrl_reg.memory_access_order[0]) begin
                page_next = page_step[6:0];
                if (page_step[7]) begin
                  col_next = col_step[6:0];
                end
              end else begin
                col_next = col_step[6:0];
                if (col_step[7]) begin
                  page_next = page_step[6:0];
                end
              end
            end
          end
          default: begin
          end
        endcase
      end
    end

    // signed nine-bit sum cannot overflow for two seven-bit operands
    alpha = 9'({2'h0, voltage_reg} + {2'h0, contrast_reg} -
               lcd_pixel_pkg::CONTRAST_OFFSET);
    if (alpha[8]) begin
      level_next = '0;
    end else if (alpha > lcd_pixel_pkg::CONTRAST_MAX) begin
      level_next = lcd_pixel_pkg::CONTRAST_MAX[6:0];
    end else begin
      level_next = alpha[6:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg      <= lcd_pixel_pkg::ST_IDLE;
      ctrl_reg       <= lcd_pixel_pkg::CTRL_RESET;
      cmd_reg        <= '0;
      count_reg      <= '0;
      phase_reg      <= '0;
      hold_reg       <= '0;
      col_first_reg  <= '0;
      col_last_reg   <= lcd_pixel_pkg::COLUMN_LAST_RESET;
      page_first_reg <= '0;
      page_last_reg  <= lcd_pixel_pkg::PAGE_LAST_RESET;
      col_reg        <= '0;
      page_reg       <= '0;
      voltage_reg    <= lcd_pixel_pkg::VOLTAGE_RESET;
      contrast_reg   <= lcd_pixel_pkg::CONTRAST_RESET;
      level_reg      <= '0;
      pix_count_reg  <= '0;
      for (int i = 0; i < lcd_pixel_pkg::TABLE_DEPTH; i++) begin
        table_reg[i] <= '0;
      end
    end else begin
      state_reg      <= state_next;
      ctrl_reg       <= ctrl_next;
      cmd_reg        <= cmd_next;
      count_reg      <= count_next;
      phase_reg      <= phase_next;
      hold_reg       <= hold_next;
      col_first_reg  <= col_first_next;
      col_last_reg   <= col_last_next;
      page_first_reg <= page_first_next;
      page_last_reg  <= page_last_next;
      col_reg        <= col_next;
      page_reg       <= page_next;
      voltage_reg    <= voltage_next;
      contrast_reg   <= contrast_next;
      level_reg      <= level_next;
      pix_count_reg  <= pix_count_next;
      table_reg      <= table_next;
    end
  end

  // ==================
  // power selects
  assign contrast_level      = level_reg;
  assign resistor_select_bit = ctrl_reg.resistor_select_bit;
  assign temp_gradient       = ctrl_reg.temp_gradient;
  assign bias_select_msb     = ctrl_reg.bias_select[2];
  assign bias_select_mid     = ctrl_reg.bias_select[1];
  assign bias_select_lsb     = ctrl_reg.bias_select[0];

  // ==================
  // two-entry pixel buffer, head always in slot 0
  assign pixel_valid = (buf_count_reg != 2'h0);
  assign pixel_out   = buf_reg[0];
  assign pop         = pixel_valid & pixel_ready;

  always_comb begin
    buf_next       = buf_reg;
    buf_count_next = buf_count_reg;
    if (pop) begin
      buf_next[0]    = buf_reg[1];
      buf_count_next = 2'(buf_count_next - 2'h1);
    end
    if (push_valid) begin
      buf_next[buf_count_next[0]] = push_data;
      buf_count_next              = 2'(buf_count_next + 2'h1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_reg[0]    <= '0;
      buf_reg[1]    <= '0;
      buf_count_reg <= '0;
    end else begin
      buf_reg       <= buf_next;
      buf_count_reg <= buf_count_next;
    end
  end

  // ==================
  // avalon slave: one wait state, read data captured in the first cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  always_comb begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (avs_read & ~ack_reg) begin
      case (avs_address)
        lcd_pixel_pkg::REG_CTRL:        rdata_next = 32'(ctrl_reg);
        lcd_pixel_pkg::REG_VOLTAGE:     rdata_next = 32'(voltage_reg);
        lcd_pixel_pkg::REG_CONTRAST:    rdata_next = 32'(contrast_reg);
        lcd_pixel_pkg::REG_STATUS:      rdata_next = {20'h0,
                                          state_reg == lcd_pixel_pkg::ST_WRITE,
                                          ~host_ready, phase_reg, 1'b0,
                                          level_reg};
        lcd_pixel_pkg::REG_PIXEL_COUNT: rdata_next = 32'(pix_count_reg);
        default:                        rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

endmodule : lcd_pixel_write_and_contrast

`default_nettype wire

// >>> tb_top.sv
// self-checking testbench for the pixel write block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic                           ref_clk = 1'b0, rst = 1'b1;
  logic [4:0]                     avs_address = '0;
  logic                           avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0]                    avs_writedata = '0, avs_readdata;
  logic                           avs_waitrequest, pixel_valid;
  logic                           host_valid, host_ready;
  logic                           chip_select_n, read_strobe_n;
  lcd_pixel_pkg::host_byte_type   host_byte;
  lcd_pixel_pkg::pixel_write_type pixel_out, got[$];
  logic                           pixel_ready = 1'b0, stall = 1'b0;
  logic [6:0]                     contrast_level;
  logic [1:0]                     temp_gradient;
  logic                           resistor_select_bit, bias_select_lsb;
  logic                           bias_select_msb, bias_select_mid;
  logic [31:0]                    seed = 32'h32F6AC88, rs = 32'h32F6AC88;
  logic [3:0]                     tbl[20];
  int                             fail_count = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  lcd_pixel_write_and_contrast dut_u (.ref_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
    .avs_readdata, .avs_waitrequest, .host_valid, .host_ready, .host_byte,
    .chip_select_n, .read_strobe_n, .pixel_valid, .pixel_ready, .pixel_out,
    .contrast_level, .resistor_select_bit, .temp_gradient, .bias_select_msb,
    .bias_select_mid, .bias_select_lsb);
  host_model host_u (.ref_clk, .host_ready, .host_valid, .host_byte,
    .chip_select_n, .read_strobe_n);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'hA3000000 : x >> 1;
  endfunction : lfsr
  function automatic logic [6:0] clamp(input int v, input int c);
    int s = v + c - 63;
    return s < 0 ? 7'h00 : (s > 127 ? 7'h7F : 7'(s));
  endfunction : clamp
  function automatic logic [13:0] place(input logic [2:0] o, input bit i);
    logic [6:0] c, p;
    c = o[1] ? 7'h67 : 7'h00;
    p = o[2] ? 7'h53 : 7'h00;
    if (i && o[0]) p = o[2] ? 7'h52 : 7'h01;
    if (i && !o[0]) c = o[1] ? 7'h66 : 7'h01;
    return {c, p};
  endfunction : place
  // ==================
  // receiver with random stalls
  always @(posedge ref_clk) begin
    if (pixel_valid && pixel_ready) got.push_back(pixel_out);
    rs <= lfsr(rs);
    pixel_ready <= !stall && rs[0];
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : av
  task automatic wait_px(input int n);
    for (int k = 0; k < 300 && got.size() < n; k++) @(posedge ref_clk);
    chk("count", 32'(got.size()), 32'(n));
  endtask : wait_px
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test;
  end
  // ==================
  // main sequence
  initial begin
    logic [31:0] q;
    logic [7:0] b[4];
    logic [6:0] v, c;
    logic [6:0] vt[6] = '{7'h00, 7'h3F, 7'h7F, 7'h64, 7'h7F, 7'h40};
    logic [6:0] ct[6] = '{7'h00, 7'h00, 7'h7F, 7'h0A, 7'h3F, 7'h00};
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    av(0, lcd_pixel_pkg::REG_VOLTAGE, 0, q);
    chk("voltage", q, 32'h3F);
    av(0, 5'h14, 0, q);
    chk("unmapped", q, 0);
    for (int g = 0; g < 4; g++) begin
      seed = lfsr(seed);
      av(1, lcd_pixel_pkg::REG_CTRL, 32'({seed[2:0], 2'(g), g[0], 4'h0}), q);
      @(negedge ref_clk);
      chk("resistor", 32'(resistor_select_bit), 32'(g[0]));
      chk("gradient", 32'(temp_gradient), 32'(g));
      chk("bias", 32'({bias_select_msb, bias_select_mid, bias_select_lsb}),
          32'(seed[2:0]));
      @(posedge ref_clk);
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = i < 6 ? vt[i] : seed[6:0];
      c = i < 6 ? ct[i] : seed[14:8];
      av(1, lcd_pixel_pkg::REG_VOLTAGE, 32'(v), q);
      av(1, lcd_pixel_pkg::REG_CONTRAST, 32'(c), q);
      @(negedge ref_clk);
      chk("level", 32'(contrast_level), 32'(clamp(v, c)));
      @(posedge ref_clk);
    end
    host_u.send(0, lcd_pixel_pkg::CMD_WRITE_CONTRAST);
    host_u.send(1, 8'h05);
    host_u.idle();
    repeat (2) @(posedge ref_clk);
    chk("cmd level", 32'(contrast_level), 32'(clamp(v, 5)));
    for (int o = 0; o < 8; o++) begin
      av(1, lcd_pixel_pkg::REG_CTRL, 32'({3'(o), 1'b0}), q);
      host_u.send(0, lcd_pixel_pkg::CMD_MEMORY_WRITE);
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        b[k] = seed[7:0];
        host_u.send(1, b[k]);
      end
      host_u.idle();
      wait_px(2);
      chk("pixel0", 32'(got[0].pixel), 32'({b[0], b[1][7:4]}));
      chk("pixel1", 32'(got[1].pixel), 32'({b[1][3:0], b[2]}));
      chk("place0", 32'({got[0].column, got[0].page}), 32'(place(3'(o), 0)));
      chk("place1", 32'({got[1].column, got[1].page}), 32'(place(3'(o), 1)));
      got.delete();
    end
    host_u.send(0, lcd_pixel_pkg::CMD_MEMORY_WRITE);
    host_u.send(1, 8'hA5);
    host_u.send(0, lcd_pixel_pkg::CMD_MEMORY_WRITE);
    host_u.idle();
    repeat (10) @(posedge ref_clk);
    chk("lone byte", 32'(got.size()), 0);
    host_u.send(0, lcd_pixel_pkg::CMD_COLOUR_SET);
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      tbl[i] = seed[3:0];
      host_u.send(1, seed[7:0]);
    end
    av(1, lcd_pixel_pkg::REG_CTRL, 32'h1, q);
    stall <= 1'b1;
    host_u.send(0, lcd_pixel_pkg::CMD_MEMORY_WRITE);
    host_u.junk(8'hFF);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      b[k] = seed[7:0];
      host_u.send(1, b[k]);
      if (k == 1) begin
        host_u.idle();
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("full", 32'(host_ready), 0);
        @(posedge ref_clk);
        stall <= 1'b0;
      end
    end
    host_u.idle();
    wait_px(4);
    for (int k = 0; k < 4; k++)
      chk("lookup", 32'(got[k].pixel), 32'({tbl[b[k][7:5]],
          tbl[8 + b[k][4:2]], tbl[16 + b[k][1:0]]}));
    av(0, lcd_pixel_pkg::REG_PIXEL_COUNT, 0, q);
    chk("pixel count", q, 32'h14);
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
